// [rtl/adsc_cfg.svh]
// Constants of the converter serial control block: offsets, defaults, timing
`ifndef ADSC_CFG_SVH
`define ADSC_CFG_SVH

// ****************************************************************
// Serial word layout
// ****************************************************************
`define ADSC_WORD_BITS      32        // Result bits per frame
`define ADSC_CFG_BITS       13        // Input bits that carry configuration
`define ADSC_MUX_EDGE       14        // Falling edge that switches mux in 1X
`define ADSC_PFX_UPDATE     3'h5      // Prefix 101: take the fields
`define ADSC_PFX_KEEP0      3'h0      // Prefix 000: keep settings
`define ADSC_PFX_KEEP1      3'h4      // Prefix 100: keep settings

// ****************************************************************
// Power-up settings
// ****************************************************************
`define ADSC_RST_CHAN       5'h00     // Differential, ch0 positive, ch1 negative
`define ADSC_RST_OSR        4'h3      // Oversampling ratio 256
`define ADSC_RST_DBL        1'b0      // 1X rate, no latency

// ****************************************************************
// Timing
// ****************************************************************
`define ADSC_CLK_NS         100       // Core clock period in ns
`define ADSC_EOCTEST_NS     500       // Status test time before internal clocking
`define ADSC_EOCTEST_CYC    ((`ADSC_EOCTEST_NS + `ADSC_CLK_NS - 1) / `ADSC_CLK_NS)

`endif

// [rtl/adsc_pkg.sv]
// Types and helpers of the converter serial control block
package adsc_pkg;
  `include "adsc_cfg.svh"

  // Conversion cycle states, Gray coded along convert, sleep, output
  typedef enum logic [1:0] {
    ST_CONV  = 2'b00,
    ST_SLEEP = 2'b01,
    ST_OUT   = 2'b11
  } adsc_state_t;

  // Oversampling ratio of a speed code; unused codes fall back to 256
  function automatic logic [15:0] adsc_osr_ratio(input logic [3:0] code);
    logic [15:0] r;
    r = 16'h0100;
    if (code >= 4'h1 && code <= 4'h9) begin
      r = 16'h0040 << (code - 4'h1);
    end else if (code == 4'hf) begin
      r = 16'h8000;
    end
    return r;
  endfunction
endpackage

// [rtl/adsc_ctrl.sv]
// Serial control of a four-channel delta-sigma converter: framing, configuration, busy, mux
module adsc_ctrl
  import adsc_pkg::*;
#(
  parameter int CYC_PER_OSR      = 20,  // Core cycles per oversampling step
  parameter int SCLK_HALF_CYCLES = 1    // Half period of the internal serial clock
) (
  input  wire logic        i_clock,          // Core clock
  input  wire logic        i_rst,            // Synchronous reset, active high
  input  wire logic        i_sclk,           // Serial clock as seen at the pin
  input  wire logic        i_cs_n,           // Chip select pin, active low
  input  wire logic        i_sdi,            // Serial data in
  input  wire logic        i_sclk_source_sel,// High: internal serial clock
  input  wire logic [28:0] i_mod_data,       // Internal conversion result
  output logic             o_busy,           // Conversion in progress
  output logic             o_sdo,            // Serial data out
  output logic             o_sdo_oe_n,       // Low while data out is driven
  output logic             o_sclk,           // Internal serial clock out
  output logic             o_sclk_oe_n,      // Low while serial clock is driven
  output logic [4:0]       o_mux_chan,       // Channel word on the input mux
  output logic [3:0]       o_osr_code,       // Speed code in use
  output logic             o_rate_double,    // 2X mode in use
  output logic             o_chop,           // Second half of a 1X conversion
  output logic             o_result_valid,   // Last result is valid
  output logic             o_result_settling // Last result noise still settling
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (CYC_PER_OSR < 1 || CYC_PER_OSR > 65535) begin : g_bad_osr
    $error("CYC_PER_OSR out of range");
  end
  if (SCLK_HALF_CYCLES < 1 || SCLK_HALF_CYCLES > 255) begin : g_bad_half
    $error("SCLK_HALF_CYCLES out of range");
  end

  // ****************************************************************
  // Link side, clocked by the serial clock pin
  // ****************************************************************
  logic        lrst_m_q, lrst_s_q;   // Reset carried into the link domain
  logic        ep_seen_q;            // Last epoch opened as a frame
  logic [5:0]  rcnt_q;               // Rising edges counted in this frame
  logic [5:0]  fseen_q;              // Last edge index handled on the fall
  logic [11:0] cfg_sr_q;             // Configuration bits gathered so far
  logic [12:0] cfg_q;                // Complete configuration word
  logic [31:0] lword_q;              // Result word copied for shifting
  logic        start_tgl_q;          // Toggles on a frame's first edge
  logic        cfg_tgl_q;            // Toggles when thirteen bits are in
  logic        mux_tgl_q;            // Toggles on the fourteenth fall
  logic        end_tgl_q;            // Toggles on the last fall
  logic        lfr_q;                // Link is presenting result bits
  logic        sdo_bit_q;            // Bit presented on data out

  // Core state that the link reads
  logic        ep_q;                 // Toggles when a result is ready
  logic [31:0] word_q;               // Result word, stable through a frame

  // Reset reaches the link only while its clock runs
  always_ff @(posedge i_sclk) begin
    lrst_m_q <= i_rst;
    lrst_s_q <= lrst_m_q;
  end

  // Rising edges: open frame, count, sample input
  always_ff @(posedge i_sclk) begin
    if (lrst_s_q) begin
      rcnt_q      <= 6'h00;
      ep_seen_q   <= 1'b0;
      cfg_sr_q    <= 12'h000;
      cfg_q       <= 13'h0000;
      lword_q     <= 32'h0000_0000;
      start_tgl_q <= 1'b0;
      cfg_tgl_q   <= 1'b0;
    end else if (ep_q != ep_seen_q) begin
      // Epoch is read directly: the serial clock is parked until busy falls,
      // so it is quiet here, and a synchroniser would lose the first edge
      ep_seen_q   <= ep_q;
      rcnt_q      <= 6'h01;
      cfg_sr_q    <= {11'h000, i_sdi};
      lword_q     <= word_q;
      start_tgl_q <= ~start_tgl_q;
    end else if (rcnt_q != 6'h00 && rcnt_q < 6'(`ADSC_WORD_BITS)) begin
      rcnt_q <= rcnt_q + 6'h01;
      if (rcnt_q < 6'(`ADSC_CFG_BITS - 1)) begin
        cfg_sr_q <= {cfg_sr_q[10:0], i_sdi};
      end else if (rcnt_q == 6'(`ADSC_CFG_BITS - 1)) begin
        // Only a full word is offered; a short frame leaves cfg_q alone
        cfg_q     <= {cfg_sr_q, i_sdi};
        cfg_tgl_q <= ~cfg_tgl_q;
      end
      // Later input bits fall through unused
    end
  end

  // Falling edges: shift out result bits, mark mux and end points
  always_ff @(negedge i_sclk) begin
    if (lrst_s_q) begin
      fseen_q   <= 6'h00;
      lfr_q     <= 1'b0;
      sdo_bit_q <= 1'b1;
      mux_tgl_q <= 1'b0;
      end_tgl_q <= 1'b0;
    end else if (rcnt_q != fseen_q && rcnt_q != 6'h00) begin
      fseen_q <= rcnt_q;
      if (rcnt_q < 6'(`ADSC_WORD_BITS)) begin
        lfr_q     <= 1'b1;
        sdo_bit_q <= lword_q[5'(6'(`ADSC_WORD_BITS - 1) - rcnt_q)];
      end else begin
        // Last fall: output goes to busy level, a new conversion starts
        lfr_q     <= 1'b0;
        sdo_bit_q <= 1'b1;
        end_tgl_q <= ~end_tgl_q;
      end
      if (rcnt_q == 6'(`ADSC_MUX_EDGE)) begin
        mux_tgl_q <= ~mux_tgl_q;
      end
    end
  end

  // ****************************************************************
  // Crossings into the core clock
  // ****************************************************************
  // Bit 0 start, 1 cfg, 2 mux, 3 end, 4 chip select, 5 clock source
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] sin_w;           // Raw inputs to the synchronisers
  logic [NSYNC-1:0] s1_q, s2_q, sh_q;// First, second and history stages

  assign sin_w = {i_sclk_source_sel, i_cs_n, end_tgl_q, mux_tgl_q, cfg_tgl_q, start_tgl_q};

  // Three flops per line; edge logic looks only at the second and history
  for (genvar g = 0; g < NSYNC; g++) begin : g_sync
    always_ff @(posedge i_clock) begin
      if (i_rst) begin
        s1_q[g] <= (g == 4) ? 1'b1 : 1'b0;
        s2_q[g] <= (g == 4) ? 1'b1 : 1'b0;
        sh_q[g] <= (g == 4) ? 1'b1 : 1'b0;
      end else begin
        s1_q[g] <= sin_w[g];
        s2_q[g] <= s1_q[g];
        sh_q[g] <= s2_q[g];
      end
    end
  end

  logic ev_start, ev_cfg, ev_mux, ev_end;    // One-cycle link events
  logic cs_rise, cs_low, int_clk;            // Chip select and source

  assign ev_start = s2_q[0] ^ sh_q[0];
  assign ev_cfg   = s2_q[1] ^ sh_q[1];
  assign ev_mux   = s2_q[2] ^ sh_q[2];
  assign ev_end   = s2_q[3] ^ sh_q[3];
  assign cs_rise  = s2_q[4] & ~sh_q[4];
  assign cs_low   = ~s2_q[4];
  assign int_clk  = s2_q[5];

  // ****************************************************************
  // Configuration decode
  // ****************************************************************
  logic [4:0] pend_chan_q;           // Channel for the next conversion
  logic [3:0] pend_osr_q;            // Speed code for the next conversion
  logic       pend_dbl_q;            // Rate mode for the next conversion
  logic       spd_new_q;             // Speed differs from the running one

  // Prefix 101 takes the channel, and speed and rate unless their five bits are all zero; every other prefix keeps what is there
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pend_chan_q <= `ADSC_RST_CHAN;
      pend_osr_q  <= `ADSC_RST_OSR;
      pend_dbl_q  <= `ADSC_RST_DBL;
    end else if (ev_cfg && cfg_q[12:10] == `ADSC_PFX_UPDATE) begin
      // Order: single-ended, polarity, address two, one, zero
      pend_chan_q <= cfg_q[9:5];
      if (cfg_q[4:0] != 5'h00) begin
        pend_osr_q <= cfg_q[4:1];
        pend_dbl_q <= cfg_q[0];
      end
    end
    // Prefixes 000 and 100 land here and change nothing
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  adsc_state_t  st_q;                // Convert, sleep or output
  logic [31:0]  tmr_q;               // Cycles into the current half
  logic [31:0]  conv_len;            // Cycles of one internal conversion
  logic [3:0]   osr_q;               // Speed code running now
  logic         dbl_q;               // Rate mode running now
  logic         half_q;              // 1X second half in progress
  logic [28:0]  first_q;             // First half sample in 1X
  logic [28:0]  prev_q;              // Previous raw modulator sample
  logic [4:0]   mux_q;               // Channel on the mux
  logic         swap_q;              // 2X mux moved to a new channel
  logic         abort_q;             // Last frame was cut short
  logic [3:0]   wait_q;              // Status test timer, internal clock
  logic [7:0]   div_q;               // Internal clock divider
  logic [5:0]   rises_q;             // Internal clock rising edges sent
  logic         sclk_q;              // Internal clock level
  logic         valid_q, settle_q;   // Result quality flags
  logic [28:0]  res_w;               // Result of the finishing conversion
  logic [29:0]  sum_w;               // Wide sum or difference for averaging

  // Length scales with the oversampling ratio; the unit is a parameter
  always_comb begin
    conv_len = 32'(adsc_osr_ratio(osr_q)) * 32'(CYC_PER_OSR);
  end

  // 1X cancels offset by chopping; 2X averages with the previous sample
  always_comb begin
    if (dbl_q) begin
      sum_w = {i_mod_data[28], i_mod_data} + {prev_q[28], prev_q};
    end else begin
      sum_w = {first_q[28], first_q} - {i_mod_data[28], i_mod_data};
    end
    res_w = sum_w[29:1];
  end

  // Conversion timing, result capture and state changes
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_q    <= ST_CONV;
      tmr_q   <= 32'h0000_0000;
      half_q  <= 1'b0;
      first_q <= 29'h0000_0000;
      prev_q  <= 29'h0000_0000;
      word_q  <= 32'h0000_0000;
      ep_q    <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_CONV: begin
          if (tmr_q >= conv_len - 32'h1) begin
            tmr_q <= 32'h0000_0000;
            if (!dbl_q && !half_q) begin
              // First of the two internal conversions of a 1X result
              half_q  <= 1'b1;
              first_q <= i_mod_data;
            end else begin
              // Result ready: hand the word to the link, go to sleep
              half_q <= 1'b0;
              prev_q <= i_mod_data;
              word_q <= {2'b00, ~res_w[28], res_w};
              ep_q   <= ~ep_q;
              st_q   <= ST_SLEEP;
            end
          end else begin
            tmr_q <= tmr_q + 32'h1;
          end
        end
        ST_SLEEP: begin
          // External clock waits for its first rise; internal for test time
          if (int_clk ? (cs_low && wait_q == 4'(`ADSC_EOCTEST_CYC)) : ev_start) begin
            st_q    <= ST_OUT;
            abort_q <= 1'b0;
          end
        end
        ST_OUT: begin
          if (cs_rise) begin
            st_q    <= ST_CONV;
            abort_q <= 1'b1;
          end else if (int_clk ? (rises_q == 6'(`ADSC_WORD_BITS) && div_q == 8'h00)
                               : ev_end) begin
            st_q <= ST_CONV;
          end
        end
        default: st_q <= ST_CONV;
      endcase
    end
  end

  // Settings take effect at the start of each conversion
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      osr_q     <= `ADSC_RST_OSR;
      dbl_q     <= `ADSC_RST_DBL;
      spd_new_q <= 1'b0;
    end else if (st_q == ST_OUT && (cs_rise || ev_end ||
                 (int_clk && rises_q == 6'(`ADSC_WORD_BITS) && div_q == 8'h00))) begin
      osr_q     <= pend_osr_q;
      dbl_q     <= pend_dbl_q;
      spd_new_q <= (pend_osr_q != osr_q);
    end
  end

  // Mux channel: 1X moves on the fourteenth fall, 2X at conversion end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mux_q  <= `ADSC_RST_CHAN;
      swap_q <= 1'b0;
    end else if (st_q == ST_CONV && tmr_q >= conv_len - 32'h1 && (dbl_q || half_q)) begin
      if (dbl_q) begin
        mux_q  <= pend_chan_q;
        swap_q <= (pend_chan_q != mux_q);
      end else begin
        swap_q <= 1'b0;
      end
    end else if (ev_mux && !(dbl_q && pend_dbl_q)) begin
      // A 1X frame, or a switch into 1X, moves the mux now
      mux_q <= pend_chan_q;
    end
  end

  // Quality of the result just made: one stale pair after a 2X channel move
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      valid_q  <= 1'b1;
      settle_q <= 1'b0;
    end else if (st_q == ST_CONV && tmr_q >= conv_len - 32'h1 && (dbl_q || half_q)) begin
      valid_q  <= ~(dbl_q & swap_q);
      // A mode change alone leaves both flags clean
      settle_q <= dbl_q & spd_new_q;
    end
  end

  // ****************************************************************
  // Internal serial clock
  // ****************************************************************
  // Status test wait: restarts whenever select goes high
  always_ff @(posedge i_clock) begin
    if (i_rst || st_q != ST_SLEEP || !cs_low) begin
      wait_q <= 4'h0;
    end else if (wait_q != 4'(`ADSC_EOCTEST_CYC)) begin
      wait_q <= wait_q + 4'h1;
    end
  end

  // Divider: 32 rises, then the clock rests high until the next sleep
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      div_q   <= 8'h00;
      rises_q <= 6'h00;
      sclk_q  <= 1'b0;
    end else if (st_q == ST_SLEEP) begin
      div_q   <= 8'h00;
      rises_q <= 6'h00;
      if (cs_low) begin
        sclk_q <= (wait_q == 4'(`ADSC_EOCTEST_CYC)) ? 1'b1 : 1'b0;
      end
      if (cs_low && wait_q == 4'(`ADSC_EOCTEST_CYC)) begin
        rises_q <= 6'h01;
      end
    end else if (st_q == ST_OUT && int_clk && rises_q != 6'h00) begin
      if (div_q == 8'(SCLK_HALF_CYCLES - 1)) begin
        div_q <= 8'h00;
        if (rises_q != 6'(`ADSC_WORD_BITS)) begin
          sclk_q <= ~sclk_q;
          if (!sclk_q) begin
            rises_q <= rises_q + 6'h01;
          end
        end
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic busy_q, eoc_mask_q, sdo_oe_n_q, sclk_oe_n_q;

  // Busy and status follow the state; deselect floats data out
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      busy_q      <= 1'b1;
      eoc_mask_q  <= 1'b1;
      sdo_oe_n_q  <= 1'b1;
      sclk_oe_n_q <= 1'b1;
    end else begin
      busy_q      <= (st_q == ST_CONV);
      // After an abort the link holds a stale bit; show status instead
      eoc_mask_q  <= (st_q == ST_CONV) | (st_q == ST_SLEEP && abort_q);
      sdo_oe_n_q  <= ~cs_low;
      sclk_oe_n_q <= ~int_clk;
    end
  end

  // Result bits must track the serial clock, so the final pick is a mux
  assign o_sdo             = (lfr_q && !eoc_mask_q) ? sdo_bit_q : busy_q;
  assign o_busy            = busy_q;
  assign o_sdo_oe_n        = sdo_oe_n_q;
  assign o_sclk            = sclk_q;
  assign o_sclk_oe_n       = sclk_oe_n_q;
  assign o_mux_chan        = mux_q;
  assign o_osr_code        = osr_q;
  assign o_rate_double     = dbl_q;
  assign o_chop            = half_q;
  assign o_result_valid    = valid_q;
  assign o_result_settling = settle_q;

endmodule

// [tb/adsc_ctrl_monitor.sv]
// Checker of the converter serial control ports
module adsc_ctrl_monitor #(
  parameter int CYC_PER_OSR = 20  // Core cycles per oversampling step
) (
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic       i_cs_n,
  input wire logic       o_busy,
  input wire logic       o_sdo,
  input wire logic       o_sdo_oe_n,
  input wire logic [4:0] o_mux_chan,
  input wire logic [3:0] o_osr_code,
  input wire logic       o_rate_double
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Conversion length bookkeeping
  // ****************************************************************
  logic [31:0] busy_cnt_q;  // Cycles spent converting
  logic [31:0] conv_len;    // Expected length; 1X takes two conversions
  assign conv_len = (o_rate_double ? 32'h1 : 32'h2) * CYC_PER_OSR
                    * (32'h1 << ({1'b0, o_osr_code} + 5'h05));
  // Counter restarts whenever busy is low
  always_ff @(posedge i_clock) begin
    if (i_rst || !o_busy) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 32'h1;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_pwr_dflt; $fell(i_rst) |-> o_busy && o_mux_chan == 5'h00 && o_osr_code == 4'h3
    && !o_rate_double; endproperty
  a_pwr_dflt: assert property (p_pwr_dflt) else $error("power-up settings wrong");
  property p_hiz; i_cs_n [*4] |-> o_sdo_oe_n; endproperty
  a_hiz: assert property (p_hiz) else $error("data out driven while deselected");
  property p_drv; !i_cs_n [*4] |-> !o_sdo_oe_n; endproperty
  a_drv: assert property (p_drv) else $error("data out not driven when selected");
  property p_stat; !o_sdo_oe_n && o_busy |-> o_sdo; endproperty
  a_stat: assert property (p_stat) else $error("status bit low while converting");
  property p_abort; $rose(i_cs_n) && !o_busy |-> ##[1:6] o_busy; endproperty
  a_abort: assert property (p_abort) else $error("no restart after select rise");
  property p_mux; $changed(o_mux_chan) |-> ##[0:1] !o_busy; endproperty
  a_mux: assert property (p_mux) else $error("mux moved mid conversion");
  property p_spd; $changed(o_osr_code) || $changed(o_rate_double) |-> ##[0:1] o_busy;
  endproperty
  a_spd: assert property (p_spd) else $error("speed changed outside conversion");
  property p_len; $fell(o_busy) |-> $past(busy_cnt_q) + 32'h3 >= conv_len
    && $past(busy_cnt_q) <= conv_len + 32'h3; endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
endmodule

bind adsc_ctrl adsc_ctrl_monitor #(.CYC_PER_OSR(CYC_PER_OSR)) adsc_ctrl_monitor_inst (
  .i_clock, .i_rst, .i_cs_n, .o_busy, .o_sdo, .o_sdo_oe_n, .o_mux_chan, .o_osr_code,
  .o_rate_double);

// [tb/adsc_host_model.sv]
// Behavioural serial host that clocks frames into the converter control
module adsc_host_model (
  output logic     o_sclk,  // Serial clock, still outside frames
  output logic     o_cs_n,  // Chip select, active low
  output logic     o_sdi,   // Serial data to the device
  input wire logic i_sdo    // Serial data from the device
);
  timeunit 1ns;
  timeprecision 1ns;
  logic free_run = 1'b0;  // Clock runs only while reset settles the link flops
  initial begin
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // 160 ns link clock; parks low between frames
  initial begin
    o_sclk = 1'b0;
    // Never touches the clock inside a frame, which times its own edges
    forever #80 if (free_run) o_sclk = ~o_sclk; else if (o_cs_n) o_sclk = 1'b0;
  end
  // One frame, MSB first; fewer than 32 bits aborts by raising select
  task automatic frame(input logic [12:0] word, input int nbits, output logic [31:0] rd);
    o_cs_n = 1'b0;
    #400;
    for (int k = 0; k < nbits; k++) begin
      o_sdi = (k < 13) ? word[12 - k] : ~o_sdi;
      #80 o_sclk = 1'b1;
      rd = {rd[30:0], i_sdo};  // Device shifts on falls, so rises see settled data
      #80 o_sclk = 1'b0;
    end
    #300 o_cs_n = 1'b1;
    o_sdi = ~o_sdi;  // Released line must not keep showing the last bit
  endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench of the converter serial control block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clock = 1'b0;  // Core clock
  logic        i_rst   = 1'b1;  // Synchronous reset
  logic        sclk, cs_n, sdi; // Link wires from the host
  logic        o_busy, o_sdo, o_sdo_oe_n, o_sclk, o_sclk_oe_n, o_rate_double;
  logic        o_chop, o_result_valid, o_result_settling;
  logic [4:0]  o_mux_chan;
  logic [3:0]  o_osr_code;
  logic [10:0] st;              // Busy, 2X, speed code, mux word
  logic [31:0] rd;              // Word read by the host
  int          err_total = 0;
  int          n_tests   = 0;
  assign st = {o_busy, o_rate_double, o_osr_code, o_mux_chan};
  // Core clock, 100 ns
  initial forever #50 i_clock = ~i_clock;
  // Constant sample: 1X offset removal yields zero, 2X average yields the sample
  adsc_ctrl #(.CYC_PER_OSR(1), .SCLK_HALF_CYCLES(2)) adsc_ctrl_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
    .i_sclk_source_sel(1'b0), .i_mod_data(29'h0abcdef), .o_busy(o_busy), .o_sdo(o_sdo),
    .o_sdo_oe_n(o_sdo_oe_n), .o_sclk(o_sclk), .o_sclk_oe_n(o_sclk_oe_n),
    .o_mux_chan(o_mux_chan), .o_osr_code(o_osr_code), .o_rate_double(o_rate_double),
    .o_chop(o_chop), .o_result_valid(o_result_valid), .o_result_settling(o_result_settling));
  adsc_host_model adsc_host_model_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(o_sdo));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait for the end of a conversion
  task automatic wait_idle;
    for (int k = 0; k < 3000 && o_busy !== 1'b0; k++) @(posedge i_clock);
    #1;
  endtask
  // Frame, then let the restart settle past the select synchroniser
  task automatic xfer(input logic [12:0] w, input int n);
    adsc_host_model_inst.frame(w, n, rd);
    repeat (6) @(posedge i_clock);
    #1;
  endtask
  task automatic finish_test;
    $display("checks=%0d errors=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_power_up;
    wait_idle();
    check(32'(st), 32'h060);
    xfer(13'h0000, 32);
    check(rd, 32'h2000_0000);
    check(32'(st), 32'h460);
    $display("t_power_up done");
  endtask
  task automatic t_update;
    wait_idle();
    xfer(13'h1623, 32);
    check(32'(st), 32'h631);
    wait_idle();
    xfer(13'h1000, 32);
    check(rd, 32'h20ab_cdef);
    check(32'(st), 32'h631);
    $display("t_update done");
  endtask
  task automatic t_keep_speed;
    wait_idle();
    xfer(13'h1420, 32);
    check(32'(st), 32'h631);
    wait_idle();
    check(32'(st), 32'h221);
    $display("t_keep_speed done");
  endtask
  task automatic t_abort;
    xfer(13'h1406, 10);
    check(32'(st), 32'h621);
    wait_idle();
    check(32'(o_result_valid), 32'h0);
    xfer(13'h1406, 32);
    check(rd, 32'h20ab_cdef);
    wait_idle();
    check(32'(st), 32'h060);
    $display("t_abort done");
  endtask
  // Main sequence; link clock runs through reset so its flops clear
  initial begin
    adsc_host_model_inst.free_run = 1'b1;
    repeat (4) @(posedge i_clock);
    #1 i_rst = 1'b0;
    repeat (3) @(posedge i_clock);
    adsc_host_model_inst.free_run = 1'b0;
    t_power_up();
    t_update();
    t_keep_speed();
    t_abort();
    finish_test();
  end
  // Watchdog well beyond the few thousand cycles the scenarios need
  initial begin
    #2000000;
    err_total++;
    finish_test();
  end
endmodule
